// *** core/bcw_write_host.sv ***
// Purpose: Host that runs byte-lane-ended write cycles on an asynchronous memory
// Assumes: One request at a time from user logic on clk; memory pins outside clk domain
// Notes:   Chip select and write strobe frame the cycle; the lane enables start and end it

`timescale 1ns/1ps

module bcw_write_host
   import bcw_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_data,
   input  wire logic [LANE_W-1:0] req_lanes,
   output logic                   wr_done,
   output logic                   busy,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   chip_enable_n,
   output logic                   write_enable_n,
   output logic                   output_enable_n,
   output logic                   high_lane_enable_n,
   output logic                   low_lane_enable_n,
   input  wire logic [DATA_W-1:0] mem_dq_i,
   output logic [DATA_W-1:0]      mem_dq_o,
   output logic                   mem_dq_oe,
   output logic [DATA_W-1:0]      bus_sample
);

   typedef struct packed {
      bcw_state_t        state;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANE_W-1:0] lanes;
      logic              ce_n;
      logic              we_n;
      logic [LANE_W-1:0] lane_n;
      logic              dq_oe;
      logic              done;
      logic [CNT_W-1:0]  space;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
   } bcw_regs_t;

   bcw_regs_t        r_q;
   bcw_regs_t        r_d;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_count;
   logic             tmr_expired;
   logic             start;

   bcw_phase_timer u_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .load       (tmr_load),
      .load_count (tmr_count),
      .expired    (tmr_expired)
   );

   // Next chip select fall only after a full cycle time
   assign req_ready = (r_q.state == ST_IDLE) && (r_q.space >= SPACE_FULL);
   assign start     = req_valid && req_ready;

   always_comb begin
      r_d       = r_q;
      tmr_load  = 1'b0;
      tmr_count = '0;
      r_d.done  = 1'b0;

      r_d.dq_s1 = mem_dq_i;
      r_d.dq_s2 = r_q.dq_s1;

      if (r_q.space < SPACE_FULL) begin
         r_d.space = r_q.space + 4'h1;
      end

      unique case (r_q.state)
         ST_IDLE: begin
            if (start) begin
               // Address and strobes settle before any lane falls
               r_d.addr  = req_addr;
               r_d.data  = req_data;
               r_d.lanes = req_lanes;
               r_d.ce_n  = 1'b0;
               r_d.we_n  = 1'b0;
               r_d.space = SPACE_ONE;
               r_d.state = ST_SETUP;
               tmr_load  = 1'b1;
               tmr_count = SETUP_LOAD;
            end
         end
         ST_SETUP: begin
            if (tmr_expired) begin
               // Both lanes leave one flop set on one edge
               r_d.lane_n = ~r_q.lanes;
               r_d.dq_oe  = 1'b1;
               r_d.state  = ST_PULSE;
               tmr_load   = 1'b1;
               tmr_count  = PULSE_LOAD;
            end
         end
         ST_PULSE: begin
            if (tmr_expired) begin
               // Lane rise ends the write; data held one more phase
               r_d.lane_n = LANES_OFF;
               r_d.state  = ST_RECOV;
               tmr_load   = 1'b1;
               tmr_count  = RECOV_LOAD;
            end
         end
         ST_RECOV: begin
            if (tmr_expired) begin
               r_d.ce_n  = 1'b1;
               r_d.we_n  = 1'b1;
               r_d.dq_oe = 1'b0;
               r_d.done  = 1'b1;
               r_d.state = ST_HIGH;
               tmr_load  = 1'b1;
               tmr_count = HIGH_LOAD;
            end
         end
         ST_HIGH: begin
            // Strobes stay high through this phase before any new fall
            if (tmr_expired) begin
               r_d.state = ST_IDLE;
            end
         end
         default: begin
            r_d.state  = ST_IDLE;
            r_d.ce_n   = 1'b1;
            r_d.we_n   = 1'b1;
            r_d.lane_n = LANES_OFF;
            r_d.dq_oe  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_q.state  <= ST_IDLE;
         r_q.addr   <= '0;
         r_q.data   <= '0;
         r_q.lanes  <= '0;
         r_q.ce_n   <= 1'b1;
         r_q.we_n   <= 1'b1;
         r_q.lane_n <= LANES_OFF;
         r_q.dq_oe  <= 1'b0;
         r_q.done   <= 1'b0;
         // A cut cycle may have just dropped chip select
         r_q.space  <= SPACE_ONE;
         r_q.dq_s1  <= '0;
         r_q.dq_s2  <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign wr_done            = r_q.done;
   assign busy               = (r_q.state != ST_IDLE);
   assign mem_addr           = r_q.addr;
   assign chip_enable_n      = r_q.ce_n;
   assign write_enable_n     = r_q.we_n;
   // Output enable never falls, so the memory never drives the data pins
   assign output_enable_n    = 1'b1;
   assign high_lane_enable_n = r_q.lane_n[LANE_HIGH];
   assign low_lane_enable_n  = r_q.lane_n[LANE_LOW];
   assign mem_dq_o           = r_q.data;
   assign mem_dq_oe          = r_q.dq_oe;
   assign bus_sample         = r_q.dq_s2;

endmodule

// *** core/bcw_pkg.sv ***
// Purpose: Constants and types for the byte-lane-ended write host controller
// Assumes: 100 MHz clock, asynchronous 16-bit memory with 20-bit word address
// Notes:   Times are in ns as printed; cycle counts are derived by rounding up

package bcw_pkg;

   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int LANE_W = 2;
   localparam int CNT_W  = 4;

   localparam int CLK_PERIOD_PS = 10000;

   // Minimum times, ns
   localparam int T_CYCLE_NS     = 35;
   localparam int T_ADDR_SETUP_NS = 0;
   localparam int T_ADDR_END_NS  = 20;
   localparam int T_PULSE_NS     = 15;
   localparam int T_DATA_END_NS  = 10;
   localparam int T_RECOVERY_NS  = 12;
   localparam int T_HIGH_NS      = 2;

   // Least time to whole cycles, at least one
   function automatic int min_cycles(input int t_ns);
      int c;
      c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam int CYCLE_CYC  = min_cycles(T_CYCLE_NS);
   localparam int SETUP_CYC  = min_cycles(T_ADDR_SETUP_NS);
   localparam int PULSE_CYC  = max2(max2(min_cycles(T_PULSE_NS), min_cycles(T_DATA_END_NS)),
                                    max2(1, min_cycles(T_ADDR_END_NS) - SETUP_CYC));
   localparam int RECOV_CYC  = min_cycles(T_RECOVERY_NS);
   localparam int HIGH_CYC   = min_cycles(T_HIGH_NS);

   localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] RECOV_LOAD = CNT_W'(RECOV_CYC - 1);
   localparam logic [CNT_W-1:0] HIGH_LOAD  = CNT_W'(HIGH_CYC - 1);
   localparam logic [CNT_W-1:0] SPACE_FULL = CNT_W'(CYCLE_CYC);
   localparam logic [CNT_W-1:0] SPACE_ONE  = 4'h1;

   localparam logic [LANE_W-1:0] LANES_OFF = 2'h3;
   localparam int LANE_HIGH = 1;
   localparam int LANE_LOW  = 0;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_PULSE = 5'b00100,
      ST_RECOV = 5'b01000,
      ST_HIGH  = 5'b10000
   } bcw_state_t;

endpackage

// *** core/bcw_phase_timer.sv ***
// Purpose: Down counter that times one phase of the write cycle
// Assumes: load comes from logic on the same clock
// Notes:   expired is high while the count stands at zero

`timescale 1ns/1ps

module bcw_phase_timer
   import bcw_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_count,
   output logic                  expired
);

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;

   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = load_count;
      end else if (count_q != '0) begin
         count_d = count_q - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign expired = (count_q == '0);

endmodule

// *** tb/bcw_write_host_props.sv ***
// Purpose: Timing checks on the byte-lane-ended write host
// Assumes: Sees only the ports of bcw_write_host
// Notes:   Bound after the module
`timescale 1ns/1ps
module bcw_write_host_props
   import bcw_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic              wr_done,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              chip_enable_n,
   input wire logic              write_enable_n,
   input wire logic              output_enable_n,
   input wire logic              high_lane_enable_n,
   input wire logic              low_lane_enable_n,
   input wire logic [DATA_W-1:0] mem_dq_o,
   input wire logic              mem_dq_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_done_after_take: assert property (req_valid && req_ready |-> ##6 wr_done)
      else $error("done not six cycles after take");
   a_write_in_frame: assert property (!high_lane_enable_n || !low_lane_enable_n |->
      !chip_enable_n && !write_enable_n) else $error("lane low outside frame");
   a_oe_held_high: assert property (output_enable_n) else $error("output enable low");
   a_strobe_high_hold: assert property ($rose(write_enable_n) || $rose(chip_enable_n)
      |=> write_enable_n && chip_enable_n) else $error("strobe high too short");
   a_lane_high_hold: assert property ($rose(high_lane_enable_n) || $rose(low_lane_enable_n)
      |=> high_lane_enable_n && low_lane_enable_n) else $error("lane high too short");
   a_lane_skew_zero: assert property (!high_lane_enable_n && !low_lane_enable_n
      |=> high_lane_enable_n == low_lane_enable_n) else $error("lane enables skewed");
   a_select_spacing: assert property ($fell(chip_enable_n)
      |=> !$fell(chip_enable_n) [*3]) else $error("chip select falls too close");
   a_addr_held: assert property ($fell(chip_enable_n) |=> $stable(mem_addr) [*5])
      else $error("address moved in cycle");
   a_lane_pulse: assert property ($fell(low_lane_enable_n) |=> !low_lane_enable_n ##1
      low_lane_enable_n) else $error("lane pulse not two cycles");
   a_data_before_end: assert property ($rose(low_lane_enable_n) |->
      mem_dq_oe && $past(mem_dq_oe, 2) && $stable(mem_dq_o)) else $error("data late");
endmodule
bind bcw_write_host bcw_write_host_props u_props (.*);

// *** tb/bcw_mem_model.sv ***
// Purpose: Behavioural word memory written by the lane enables
// Assumes: Host keeps output enable high
// Notes:   Undriven pins show the inverse of the host data
`timescale 1ns/1ps
module bcw_mem_model
   import bcw_pkg::*;
(
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              chip_enable_n,
   input  wire logic              write_enable_n,
   input  wire logic              high_lane_enable_n,
   input  wire logic              low_lane_enable_n,
   input  wire logic [DATA_W-1:0] mem_dq_o,
   input  wire logic              mem_dq_oe,
   output logic      [DATA_W-1:0] mem_dq_i
);
   logic [DATA_W-1:0] mem [int];
   function automatic logic [DATA_W-1:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 16'h0000;
   endfunction
   task automatic put(input int a, input logic [DATA_W-1:0] m);
      mem[a] = (rd(a) & ~m) | (mem_dq_i & m);
   endtask
   assign mem_dq_i = mem_dq_oe ? mem_dq_o : ~mem_dq_o;
   always @(posedge low_lane_enable_n) if (!chip_enable_n && !write_enable_n) put(mem_addr, 16'h00ff);
   always @(posedge high_lane_enable_n) if (!chip_enable_n && !write_enable_n) put(mem_addr, 16'hff00);
endmodule

// *** tb/bcw_write_host_tb_top.sv ***
// Purpose: Self-checking bench for the write host
// Assumes: 100 MHz clock, memory model on the far side
// Notes:   Expected words kept in a scoreboard array
`timescale 1ns/1ps
module bcw_write_host_tb_top;
   import bcw_pkg::*;
   logic clk, rst_n, req_valid, req_ready, wr_done, busy, mem_dq_oe;
   logic chip_enable_n, write_enable_n, output_enable_n, high_lane_enable_n, low_lane_enable_n;
   logic [ADDR_W-1:0] req_addr, mem_addr;
   logic [DATA_W-1:0] req_data, mem_dq_o, mem_dq_i, bus_sample, w, h1, h2;
   logic [LANE_W-1:0] req_lanes;
   int seed = 76267, miscompares = 0, checked = 0, cyc = 0, live = 0, a, d, l;
   int q_t[$], q_a[$], q_d[$], q_l[$];
   logic [DATA_W-1:0] exp_m [int];
   bcw_write_host dut (.*);
   bcw_mem_model u_mem (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task finish_test;
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_cyc(input int got, input int exp);
      checked++;
      if (got != exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Valid stays up between calls, so requests go back to back
   task send(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] da, input logic [LANE_W-1:0] la);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_addr <= ad;
      req_data <= da;
      req_lanes <= la;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      chk_cyc(n < 20, 1);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (!rst_n) begin
         live = 0;
         q_t.delete();
         q_a.delete();
         q_d.delete();
         q_l.delete();
      end else begin
         live++;
         chk_flag(busy, q_t.size() > 0);
         // Pins reach bus_sample two edges after they are seen
         if (live >= 3) chk_word(bus_sample, h2);
         if (wr_done !== 1'b0) chk_cyc(q_t.size(), 1);
         if (req_valid && req_ready === 1'b1) begin
            q_t.push_back(cyc);
            q_a.push_back(req_addr);
            q_d.push_back(req_data);
            q_l.push_back(req_lanes);
         end
         if (wr_done === 1'b1 && q_t.size() > 0) begin
            chk_cyc(cyc - q_t.pop_front(), 6);
            a = q_a.pop_front();
            d = q_d.pop_front();
            l = q_l.pop_front();
            w = exp_m.exists(a) ? exp_m[a] : 16'h0000;
            if (l[0]) w[7:0] = d[7:0];
            if (l[1]) w[15:8] = d[15:8];
            exp_m[a] = w;
            chk_word(u_mem.rd(a), w);
         end
      end
      h2 = h1;
      h1 = mem_dq_i;
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_addr = '0;
      req_data = '0;
      req_lanes = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 40; i++) send(20'($random(seed)) & 20'h0000f, 16'($random(seed)), 2'(i));
      send(20'hfffff, 16'ha5c3, 2'h3);
      send(20'h00003, 16'h1234, 2'h3);
      rst_n <= 1'b0;
      req_valid <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      send(20'h00003, 16'h5678, 2'h1);
      req_valid <= 1'b0;
      repeat (10) @(posedge clk);
      chk_cyc(q_t.size(), 0);
      finish_test;
   end
   initial begin
      #50000;
      miscompares++;
      finish_test;
   end
endmodule
